/* can_rx_fifo_store.sv */
// Receive FIFO store engine: writes accepted frames into RAM buffers as bus master.
// Assumes a protocol engine that presents one accepted frame and holds it valid until frame_ready,
// filter matching already done upstream, and a RAM write port with ready handshake.
`timescale 1ns/100ps
`default_nettype none
module can_rx_fifo_store
  import can_rx_store_pkg::*;
#(
  parameter int DEPTH_W = 5
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  // Accepted frame from protocol engine and filters
  input  wire logic                              frame_valid,
  input  wire logic [can_rx_store_pkg::FILTER_W-1:0]   frame_filter,
  input  wire logic [can_rx_store_pkg::FIFO_SEL_W-1:0] filter_fifo_select,
  input  wire logic [10:0]                       frame_sid,
  input  wire logic [17:0]                       frame_eid,
  input  wire logic                              frame_ide,
  input  wire logic                              frame_rtr,
  input  wire logic                              frame_rb1,
  input  wire logic                              frame_rb0,
  input  wire logic [3:0]                        frame_dlc,
  input  wire logic [63:0]                       frame_data,
  output logic                                   frame_ready,
  // Timestamp and module control
  input  wire logic [15:0]                       timestamp_timer,
  input  wire logic                              timestamp_capture_enable,
  // The selected FIFO's configuration (one FIFO context served per frame)
  input  wire logic [31:0]                       fifo_base_address,
  input  wire logic [DEPTH_W-1:0]                fifo_size_m1,
  input  wire logic [31:0]                       fifo_control_register,
  input  wire logic                              user_increment,
  input  wire logic                              overflow_clear,
  input  wire logic [3:0]                        fifo_int_enable,
  // RAM master write port
  output logic                                   ram_wr_valid,
  output logic [31:0]                            ram_wr_addr,
  output logic [31:0]                            ram_wr_data,
  input  wire logic                              ram_wr_ready,
  // Status
  output logic [DEPTH_W-1:0]                     module_fifo_index,
  output logic [31:0]                            user_read_address,
  output logic                                   rx_overflow_flag,
  output logic                                   rx_full_flag,
  output logic                                   rx_not_empty_flag,
  output logic                                   rx_half_full_flag,
  output logic                                   fifo_pending_bit,
  output logic [31:0]                            interrupt_code_register,
  output logic                                   fifo_irq
);
  import can_rx_store_pkg::*;

  // ==========================================================================
  // Frame capture and buffer formatting
  // ==========================================================================
  store_state_t state_q, state_d;
  logic [31:0]  w0_q, w0_d, w1_q, w1_d, w2_q, w2_d, w3_q, w3_d;
  logic [31:0]  buf_addr_q, buf_addr_d;
  logic         pay_only_q, pay_only_d;
  logic [FILTER_W-1:0] hit_q, hit_d;
  logic [FIFO_SEL_W-1:0] sel_q, sel_d;
  logic [6:0]   code_q, code_d;
  logic [4:0]   fhit_q, fhit_d;
  logic         store_pulse, drop_pulse;
  logic [DEPTH_W-1:0] mi, ui;
  logic         full_w;
  logic [31:0]  buf_size;
  logic [63:0]  payload;
  logic         payload_only;

  // Bytes beyond the length code are forced to zero (payload-only storage; full format stores frame_data as received)
  function automatic logic [63:0] mask_payload(input logic [63:0] d, input logic [3:0] dlc);
    logic [3:0] n;
    logic [63:0] m;
    n = dlc[3] ? DLC_MAX_BYTES : dlc;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      m[i*8 +: 8] = (4'(i) < n) ? d[i*8 +: 8] : FILL_BYTE;
    end
    mask_payload = m;
  endfunction

  function automatic logic [31:0] buf_offset(input logic [DEPTH_W-1:0] idx,
                                             input logic [31:0] size);
    buf_offset = 32'(idx) * size;
  endfunction

  assign payload_only = fifo_control_register[PAYLOAD_ONLY_BIT];
  assign payload      = mask_payload(frame_data, frame_dlc);
  assign buf_size     = pay_only_q ? PAYLOAD_BUF_SIZE : FULL_BUF_SIZE;

  always_comb begin
    state_d    = state_q;
    w0_d       = w0_q;
    w1_d       = w1_q;
    w2_d       = w2_q;
    w3_d       = w3_q;
    buf_addr_d = buf_addr_q;
    pay_only_d = pay_only_q;
    hit_d      = hit_q;
    sel_d      = sel_q;
    drop_pulse = 1'b0;
    store_pulse = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (frame_valid) begin
          if (full_w) begin
            drop_pulse = 1'b1;
          end else begin
            // Select FIFO given by the matching filter
            pay_only_d = payload_only;
            hit_d   = frame_filter;
            sel_d   = filter_fifo_select;
            buf_addr_d = fifo_base_address + buf_offset(mi,
                           payload_only ? PAYLOAD_BUF_SIZE : FULL_BUF_SIZE);
            if (payload_only) begin
              w0_d = payload[31:0];
              w1_d = payload[63:32];
            end else begin
              w0_d = '0;
              w0_d[TS_LSB +: 16]       = timestamp_capture_enable ?
                                         timestamp_timer : 16'h0000;
              w0_d[HIT_FIELD_LSB +: 5] = frame_filter;
              w0_d[SID_LSB +: 11]      = frame_sid;
              w1_d = '0;
              w1_d[SRR_POS]            = frame_ide;
              w1_d[IDE_POS]            = frame_ide;
              w1_d[EID_LSB +: 18]      = frame_eid;
              w1_d[RTR_POS]            = frame_rtr;
              w1_d[RB1_POS]            = frame_rb1;
              w1_d[RB0_POS]            = frame_rb0;
              w1_d[DLC_LSB +: 4]       = frame_dlc;
              w2_d = frame_data[31:0];
              w3_d = frame_data[63:32];
            end
            state_d = ST_WR0;
          end
        end
      end
      ST_WR0: begin
        if (ram_wr_ready) begin
          state_d = ST_WR1;
        end
      end
      ST_WR1: begin
        if (ram_wr_ready) begin
          state_d = pay_only_q ? ST_DONE : ST_WR2;
        end
      end
      ST_WR2: begin
        if (ram_wr_ready) begin
          state_d = ST_WR3;
        end
      end
      ST_WR3: begin
        if (ram_wr_ready) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // Index advances only once every word has landed in RAM
        store_pulse = 1'b1;
        state_d     = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      w0_q       <= '0;
      w1_q       <= '0;
      w2_q       <= '0;
      w3_q       <= '0;
      buf_addr_q <= '0;
      pay_only_q <= 1'b0;
      hit_q      <= '0;
      sel_q      <= '0;
    end else begin
      state_q    <= state_d;
      w0_q       <= w0_d;
      w1_q       <= w1_d;
      w2_q       <= w2_d;
      w3_q       <= w3_d;
      buf_addr_q <= buf_addr_d;
      pay_only_q <= pay_only_d;
      hit_q      <= hit_d;
      sel_q      <= sel_d;
    end
  end

  // ==========================================================================
  // RAM write port
  // ==========================================================================
  always_comb begin
    ram_wr_valid = 1'b0;
    ram_wr_addr  = buf_addr_q;
    ram_wr_data  = w0_q;
    unique case (state_q)
      ST_WR0: begin
        ram_wr_valid = 1'b1;
        ram_wr_addr  = buf_addr_q + OFS_WORD0;
        ram_wr_data  = w0_q;
      end
      ST_WR1: begin
        ram_wr_valid = 1'b1;
        ram_wr_addr  = buf_addr_q + OFS_WORD1;
        ram_wr_data  = w1_q;
      end
      ST_WR2: begin
        ram_wr_valid = 1'b1;
        ram_wr_addr  = buf_addr_q + OFS_WORD2;
        ram_wr_data  = w2_q;
      end
      ST_WR3: begin
        ram_wr_valid = 1'b1;
        ram_wr_addr  = buf_addr_q + OFS_WORD3;
        ram_wr_data  = w3_q;
      end
      ST_IDLE, ST_DONE: begin
        ram_wr_valid = 1'b0;
      end
    endcase
  end

  // Frames wait while a store is in progress; the engine must hold them
  assign frame_ready = (state_q == ST_IDLE);

  // ==========================================================================
  // Occupancy and flags
  // ==========================================================================
  can_rx_occupancy #(
    .DEPTH_W (DEPTH_W)
  ) u_occ (
    .clk          (clk),
    .rst          (rst),
    .size_m1      (fifo_size_m1),
    .store        (store_pulse | drop_pulse),
    .release_buf  (user_increment),
    .overflow_clr (overflow_clear),
    .module_index (mi),
    .user_index   (ui),
    .full         (full_w),
    .not_empty    (rx_not_empty_flag),
    .half_full    (rx_half_full_flag),
    .overflow     (rx_overflow_flag)
  );

  assign module_fifo_index = mi;
  assign rx_full_flag      = full_w;
  assign user_read_address = fifo_base_address + buf_offset(ui, buf_size);

  // ==========================================================================
  // Pending bit, interrupt and interrupt code
  // ==========================================================================
  logic [3:0] events;
  logic       pend_q, pend_d;

  assign events = {rx_overflow_flag, rx_full_flag, rx_half_full_flag, rx_not_empty_flag};

  always_comb begin
    pend_d = |(events & fifo_int_enable);
    fhit_d = fhit_q;
    if (store_pulse) begin
      code_d = 7'(sel_q);
      fhit_d = hit_q;
    end else if (pend_d) begin
      // A late enable still names the FIFO latched with the frame
      code_d = 7'(sel_q);
    end else begin
      code_d = CODE_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      code_q <= CODE_NONE;
      fhit_q <= '0;
    end else begin
      pend_q <= pend_d;
      code_q <= code_d;
      fhit_q <= fhit_d;
    end
  end

  assign fifo_pending_bit = pend_q;
  assign fifo_irq         = pend_q;
  always_comb begin
    interrupt_code_register = '0;
    interrupt_code_register[CODE_LSB +: 7] = code_q;
    interrupt_code_register[FHIT_LSB +: 5] = fhit_q;
  end
endmodule // can_rx_fifo_store
`default_nettype wire

/* can_rx_occupancy.sv */
// Occupancy tracker and flag logic for one receive FIFO.
// Assumes store and release requests come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module can_rx_occupancy #(
  parameter int DEPTH_W = 5
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [DEPTH_W-1:0] size_m1,
  input  wire logic               store,
  input  wire logic               release_buf,
  input  wire logic               overflow_clr,
  output logic [DEPTH_W-1:0]      module_index,
  output logic [DEPTH_W-1:0]      user_index,
  output logic                    full,
  output logic                    not_empty,
  output logic                    half_full,
  output logic                    overflow
);
  import can_rx_store_pkg::*;
  logic [DEPTH_W:0]   count_q, count_d;
  logic [DEPTH_W-1:0] mi_q, mi_d, ui_q, ui_d;
  logic               ovf_q, ovf_d;
  logic               do_store, do_rel;

  function automatic logic [DEPTH_W-1:0] wrap_inc(input logic [DEPTH_W-1:0] v,
                                                  input logic [DEPTH_W-1:0] last);
    wrap_inc = (v == last) ? '0 : v + 1'b1;
  endfunction

  always_comb begin
    do_store = store && !full;
    do_rel   = release_buf && not_empty;
    count_d  = count_q;
    mi_d     = mi_q;
    ui_d     = ui_q;
    ovf_d    = ovf_q && !overflow_clr;
    if (store && full) begin
      ovf_d = 1'b1;
    end
    if (do_store) begin
      mi_d = wrap_inc(mi_q, size_m1);
    end
    if (do_rel) begin
      ui_d = wrap_inc(ui_q, size_m1);
    end
    if (do_store && !do_rel) begin
      count_d = count_q + 1'b1;
    end else if (!do_store && do_rel) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      mi_q    <= '0;
      ui_q    <= '0;
      ovf_q   <= 1'b0;
    end else begin
      count_q <= count_d;
      mi_q    <= mi_d;
      ui_q    <= ui_d;
      ovf_q   <= ovf_d;
    end
  end

  assign module_index = mi_q;
  assign user_index   = ui_q;
  assign full         = (count_q == {1'b0, size_m1} + 1'b1);
  assign not_empty    = (count_q != '0);
  assign half_full    = ({count_q, 1'b0} >= ({1'b0, size_m1} + 1'b1));
  assign overflow     = ovf_q;
endmodule // can_rx_occupancy
`default_nettype wire

/* can_rx_ram_model.sv */
// System RAM write port model for the store engine.
// Assumes word addresses within a 1 KiB window; the bench may preload words.
`timescale 1ns/100ps
`default_nettype none
module can_rx_ram_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        ram_wr_valid,
  input  wire logic [31:0] ram_wr_addr,
  input  wire logic [31:0] ram_wr_data,
  output logic             ram_wr_ready
);
  // ==========================================
  // Storage
  logic [31:0] mem [0:255];
  logic        tick_q;
  // Slow mode stalls every other cycle so held requests are exercised
  assign ram_wr_ready = ram_wr_valid && (!slow || tick_q);
  always @(posedge clk) begin
    tick_q <= rst ? 1'b0 : !tick_q;
    if (ram_wr_valid && ram_wr_ready) begin
      mem[ram_wr_addr[9:2]] <= ram_wr_data;
    end
  end
endmodule // can_rx_ram_model
`default_nettype wire

/* can_rx_store_pkg.sv */
// Package for the receive FIFO store logic: buffer layout, flag and code fields.
// Assumes one clock domain and a single word-write master port to system RAM.
`default_nettype none
package can_rx_store_pkg;
  localparam int        WORD_W        = 32;
  localparam int        FIFO_SEL_W    = 5;
  localparam int        INDEX_W       = 5;
  localparam int        FILTER_W      = 5;
  // Buffer word offsets (bytes)
  localparam logic [31:0] OFS_WORD0    = 32'h0000_0000;
  localparam logic [31:0] OFS_WORD1    = 32'h0000_0004;
  localparam logic [31:0] OFS_WORD2    = 32'h0000_0008;
  localparam logic [31:0] OFS_WORD3    = 32'h0000_000C;
  localparam logic [31:0] FULL_BUF_SIZE = 32'h0000_0010;
  localparam logic [31:0] PAYLOAD_BUF_SIZE = 32'h0000_0008;
  // Word 0 fields
  localparam int TS_LSB     = 16;
  localparam int HIT_FIELD_LSB = 11;
  localparam int SID_LSB    = 0;
  // Word 1 fields
  localparam int SRR_POS    = 29;
  localparam int IDE_POS    = 28;
  localparam int EID_LSB    = 10;
  localparam int RTR_POS    = 9;
  localparam int RB1_POS    = 8;
  localparam int RB0_POS    = 4;
  localparam int DLC_LSB    = 0;
  // Control register bit for payload-only storage
  localparam int PAYLOAD_ONLY_BIT = 12;
  // Interrupt code register fields
  localparam int CODE_LSB   = 0;
  localparam int FHIT_LSB   = 8;
  localparam logic [6:0] CODE_NONE = 7'h40;
  localparam logic [3:0] DLC_MAX_BYTES = 4'h8;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WR0   = 3'b001,
    ST_WR1   = 3'b011,
    ST_WR2   = 3'b010,
    ST_WR3   = 3'b110,
    ST_DONE  = 3'b111
  } store_state_t;
endpackage
`default_nettype wire

/* can_rx_store_properties.sv */
// Port checker for the receive FIFO store engine.
// Assumes base address, size and control change only while idle and empty.
`timescale 1ns/100ps
`default_nettype none
module can_rx_store_properties #(
  parameter int DEPTH_W = 5
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               frame_valid,
  input wire logic               frame_ready,
  input wire logic [4:0]         frame_filter,
  input wire logic [31:0]        fifo_base_address,
  input wire logic [DEPTH_W-1:0] fifo_size_m1,
  input wire logic [31:0]        fifo_control_register,
  input wire logic               user_increment,
  input wire logic               overflow_clear,
  input wire logic [3:0]         fifo_int_enable,
  input wire logic               ram_wr_valid,
  input wire logic [31:0]        ram_wr_addr,
  input wire logic [31:0]        ram_wr_data,
  input wire logic               ram_wr_ready,
  input wire logic [DEPTH_W-1:0] module_fifo_index,
  input wire logic [31:0]        user_read_address,
  input wire logic               rx_overflow_flag,
  input wire logic               rx_full_flag,
  input wire logic               rx_not_empty_flag,
  input wire logic               rx_half_full_flag,
  input wire logic               fifo_pending_bit,
  input wire logic [31:0]        interrupt_code_register,
  input wire logic               fifo_irq
);
  // ==========================================
  // Helper state
  logic [4:0]  hit_q;
  logic [31:0] stride;
  logic        take;
  assign take   = frame_valid && frame_ready;
  assign stride = fifo_control_register[12] ? 32'h8 : 32'h10;
  always_ff @(posedge clk) begin
    if (take) begin
      hit_q <= frame_filter;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Properties
  chk_irq_follows: assert property (fifo_irq == fifo_pending_bit)
    else $error("irq differs from pending bit");
  chk_idle_quiet: assert property (frame_ready |-> !ram_wr_valid)
    else $error("write while idle");
  chk_first_addr: assert property (take && !rx_full_flag |=> ram_wr_valid &&
    ram_wr_addr == fifo_base_address + 32'(module_fifo_index) * stride)
    else $error("first word address wrong");
  chk_wr_hold: assert property (ram_wr_valid && !ram_wr_ready |=> ram_wr_valid &&
    $stable(ram_wr_addr) && $stable(ram_wr_data))
    else $error("write request changed before ready");
  chk_word_order: assert property (ram_wr_valid && ram_wr_ready |=>
    !ram_wr_valid || ram_wr_addr == $past(ram_wr_addr) + 32'h4)
    else $error("buffer words out of order");
  chk_full_drop: assert property (take && rx_full_flag |=> !ram_wr_valid &&
    rx_overflow_flag && $stable(module_fifo_index))
    else $error("frame not dropped when full");
  chk_ovf_sticky: assert property (rx_overflow_flag && !overflow_clear |=> rx_overflow_flag)
    else $error("overflow lost without clear");
  chk_index_step: assert property ($changed(module_fifo_index) |-> module_fifo_index ==
    (($past(module_fifo_index) == fifo_size_m1) ? '0 : $past(module_fifo_index) + 1'b1))
    else $error("index step wrong");
  chk_hit_code: assert property ($changed(module_fifo_index) |->
    interrupt_code_register[12:8] == hit_q)
    else $error("filter hit not updated");
  chk_user_step: assert property (user_increment && rx_not_empty_flag |=>
    user_read_address == (($past(user_read_address) - fifo_base_address ==
    32'(fifo_size_m1) * stride) ? fifo_base_address : $past(user_read_address) + stride))
    else $error("user address step wrong");
  chk_user_still: assert property (!user_increment |=> $stable(user_read_address))
    else $error("user address moved");
  chk_flag_nest: assert property (rx_full_flag |-> rx_half_full_flag && rx_not_empty_flag)
    else $error("full without half or not-empty");
  chk_pend_mask: assert property ((fifo_int_enable == 4'h0) [*2] |-> !fifo_pending_bit)
    else $error("pending while all disabled");
  cover property (take && rx_full_flag);
  cover property (ram_wr_valid && !ram_wr_ready);
  cover property (user_increment && rx_not_empty_flag);
endmodule // can_rx_store_properties
bind can_rx_fifo_store can_rx_store_properties #(.DEPTH_W(DEPTH_W)) can_rx_store_properties_i (.*);
`default_nettype wire

/* tb.sv */
// Testbench for the receive FIFO store engine with a RAM model.
// Assumes one FIFO of four buffers at base 0x100 and a 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import can_rx_store_pkg::*;
  logic        clk, rst, frame_valid, frame_ide, frame_rtr, frame_rb1, frame_rb0, slow;
  logic        frame_ready, timestamp_capture_enable, user_increment, overflow_clear;
  logic        ram_wr_valid, ram_wr_ready, rx_overflow_flag, rx_full_flag, fifo_irq;
  logic        rx_not_empty_flag, rx_half_full_flag, fifo_pending_bit;
  logic [4:0]  frame_filter, filter_fifo_select, module_fifo_index, fifo_size_m1;
  logic [10:0] frame_sid;
  logic [17:0] frame_eid;
  logic [3:0]  frame_dlc, fifo_int_enable;
  logic [63:0] frame_data;
  logic [15:0] timestamp_timer;
  logic [31:0] fifo_base_address, fifo_control_register, ram_wr_addr, ram_wr_data;
  logic [31:0] user_read_address, interrupt_code_register;
  int          err_total, n_checks;
  can_rx_fifo_store #(.DEPTH_W(5)) can_rx_fifo_store_i (.*);
  can_rx_ram_model can_rx_ram_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] flg();
    return {26'h0, rx_overflow_flag, rx_full_flag, rx_not_empty_flag,
            rx_half_full_flag, fifo_pending_bit, fifo_irq};
  endfunction
  function automatic logic [31:0] pay(input logic [63:0] d, input int lo, input int n);
    logic [31:0] w;
    for (int i = 0; i < 4; i++) w[8*i +: 8] = (lo + i < n) ? d[8*(lo+i) +: 8] : FILL_BYTE;
    return w;
  endfunction
  function automatic logic [31:0] code();
    return {19'h0, frame_filter, 3'b000, filter_fifo_select};
  endfunction
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("index", 32'h0, 32'(module_fifo_index));
    chk("flags", 32'h0, flg());
    chk("code", 32'h40, interrupt_code_register);
    chk("uaddr", 32'h100, user_read_address);
  endtask
  // Only frames that passed an enabled filter and mask are offered
  task automatic send();
    int n;
    n = 0;
    frame_valid = 1'b1;
    while (frame_ready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    @(negedge clk);
    frame_valid = 1'b0;
    n = 0;
    while (frame_ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    repeat (2) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic chk_full(input int w);
    chk("word0", {timestamp_timer & {16{timestamp_capture_enable}}, frame_filter, frame_sid},
        can_rx_ram_model_i.mem[w]);
    chk("word1", {2'b00, frame_ide, frame_ide, frame_eid, frame_rtr, frame_rb1, 3'b000,
        frame_rb0, frame_dlc}, can_rx_ram_model_i.mem[w+1]);
    chk("word2", frame_data[31:0], can_rx_ram_model_i.mem[w+2]);
    chk("word3", frame_data[63:32], can_rx_ram_model_i.mem[w+3]);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_full();
    slow = 1'b1;
    send();
    chk_full(64);
    chk("index", 32'h1, 32'(module_fifo_index));
    chk("flags", 32'h0B, flg());
    chk("code", code(), interrupt_code_register);
    slow = 1'b0;
    {timestamp_capture_enable, frame_ide, frame_rtr, frame_dlc} = {3'b000, 4'h2};
    send();
    chk_full(68);
    $display("test full_format done");
  endtask
  task automatic t_payload();
    do_reset();
    fifo_control_register = 32'h0000_1000;
    timestamp_capture_enable = 1'b1;
    can_rx_ram_model_i.mem[68] = 32'hA5A5_A5A5;
    frame_dlc = 4'h3;
    send();
    frame_dlc = 4'hC;
    send();
    chk("pay0", pay(frame_data, 0, 3), can_rx_ram_model_i.mem[64]);
    chk("pay1", 32'h0, can_rx_ram_model_i.mem[65]);
    chk("pay2", pay(frame_data, 0, 8), can_rx_ram_model_i.mem[66]);
    chk("pay3", pay(frame_data, 4, 8), can_rx_ram_model_i.mem[67]);
    chk("spare", 32'hA5A5_A5A5, can_rx_ram_model_i.mem[68]);
    fifo_control_register = 32'h0;
    $display("test payload_only done");
  endtask
  task automatic t_fill();
    do_reset();
    fifo_int_enable = 4'hF;
    for (int k = 1; k <= 5; k++) begin
      frame_sid = 11'(k);
      send();
      chk("index", 32'((k >= 4) ? 0 : k), 32'(module_fifo_index));
      chk("half", 32'(k >= 2), 32'(rx_half_full_flag));
      chk("full", 32'(k >= 4), 32'(rx_full_flag));
      chk("ovf", 32'(k == 5), 32'(rx_overflow_flag));
    end
    chk("dropped", 32'h1, 32'(can_rx_ram_model_i.mem[64][10:0]));
    for (int k = 1; k <= 5; k++) begin
      pulse(user_increment);
      chk("uaddr", 32'h100 + 32'(((k >= 4) ? 0 : k) * 16), user_read_address);
    end
    chk("flags", 32'h23, flg());
    pulse(overflow_clear);
    chk("flags", 32'h0, flg());
    $display("test fill_overflow done");
  endtask
  task automatic t_mask();
    fifo_int_enable = 4'h0;
    send();
    chk("flags", 32'h08, flg());
    chk("code", {19'h0, frame_filter, 8'h40}, interrupt_code_register);
    fifo_int_enable = 4'h1;
    repeat (2) @(negedge clk);
    chk("flags", 32'h0B, flg());
    chk("code", code(), interrupt_code_register);
    $display("test irq_mask done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst, frame_valid, user_increment, overflow_clear, slow} = 5'b10000;
    {frame_filter, filter_fifo_select, frame_sid, frame_eid} = {5'h1B, 5'h05, 11'h5A5, 18'h2C3D1};
    {frame_ide, frame_rtr, frame_rb1, frame_rb0, frame_dlc} = {4'b1101, 4'hA};
    frame_data = 64'h8877_6655_4433_2211;
    {timestamp_timer, timestamp_capture_enable} = {16'hBEEF, 1'b1};
    {fifo_base_address, fifo_size_m1, fifo_control_register} = {32'h100, 5'h3, 32'h0};
    fifo_int_enable = 4'h1;
    do_reset();
    t_full();
    t_payload();
    t_fill();
    t_mask();
    finish_test();
  end
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
